// file: rtl/smsc_params.svh
// constants for the synthesizer mixer serial control block
`ifndef SMSC_PARAMS_SVH
`define SMSC_PARAMS_SVH
`define SMSC_WORD_W 24
`define SMSC_SEL_W 3
`define SMSC_NUM_REGS 8
`define SMSC_SCLK_MAX_MHZ 20
// internal register indices
`define SMSC_REG_PUMP 3'd4
`define SMSC_REG_LO 3'd5
`define SMSC_REG_MON 3'd3
// field positions
`define SMSC_LO_SYNTH_BIT 6
`define SMSC_LO_DRV_BIT 3
`define SMSC_PUMP_CUR_HI 11
`define SMSC_PUMP_CUR_LO 10
`define SMSC_PUMP_EXT_BIT 18
`define SMSC_MON_SEL_BIT 4
// reset values of the internal registers
`define SMSC_DEF_R0 24'h0001c0
`define SMSC_DEF_R1 24'h003001
`define SMSC_DEF_R2 24'h001802
`define SMSC_DEF_R3 24'h000003
`define SMSC_DEF_R4 24'h000004
`define SMSC_DEF_R5 24'h000005
`define SMSC_DEF_R6 24'h000006
`define SMSC_DEF_R7 24'h000007
// bus map, byte addresses
`define SMSC_ADDR_W 8
`define SMSC_OFS_REG0 8'h00
`define SMSC_OFS_STATUS 8'h20
`define SMSC_OFS_CTRL 8'h24
`define SMSC_CTRL_HOLD_BIT 0
`define SMSC_RESP_OKAY 2'b00
`define SMSC_RESP_DECERR 2'b11
`endif

// file: rtl/smsc_pkg.sv
// types for the synthesizer mixer serial control block
package smsc_pkg;
    typedef struct packed {
        logic synth_power;
        logic lo_internal;
        logic lo_port_pos_oe;
        logic lo_port_neg_oe;
    } smsc_lo_type;
    typedef struct packed {
        logic [1:0] current_sel;
        logic ext_ref;
    } smsc_pump_type;
    typedef enum logic [1:0] {
        SMSC_WR_IDLE,
        SMSC_WR_RESP
    } smsc_wr_state_type;
endpackage

// file: rtl/smsc_top.sv
// serial programming port, lo mode control and register bus of the mixer
`timescale 1ns/1ps
`include "smsc_params.svh"
// Notes on behaviour
// R01 - shift data in on each serial clock rise
// R02 - words arrive msb first, select bits last
// R03 - low three bits pick one of eight registers
// R04 - load strobe rise commits word, never earlier; a rise while hold is set commits nothing
// R05 - controller keeps serial clock at 20 MHz max
// R06 - enable pin high: synth on, lo internal
// R07 - enable pin low: synth off, external lo
// R08 - register bit also switches synth mode
// R09 - lo pins inputs unless pin and bit high
// R10 - lo pins outputs when driver pin or bit
// R11 - floating driver pin reads as low
// R12 - two bits pick one of four pump currents
// R13 - one bit picks internal or external reference
// R14 - monitor shows reference or lock detect
// R15 - strobe low while shifting, pulsed after word
module smsc_top
    import smsc_pkg::*;
(
    // system
    input wire logic aclk,
    input wire logic aresetn,
    // serial link
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe,
    // pins and analog status
    input wire logic synth_enable_pin,
    input wire logic lo_driver_pin,
    input wire logic ref_in,
    input wire logic lock_detect,
    // mode outputs
    output smsc_pkg::smsc_lo_type lo_ctrl,
    output smsc_pkg::smsc_pump_type pump_ctrl,
    output logic monitor_out,
    // axi4-lite write address
    input wire logic [`SMSC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [`SMSC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import smsc_pkg::*;

    localparam logic [`SMSC_WORD_W-1:0] DEFS [`SMSC_NUM_REGS] = '{
        `SMSC_DEF_R0, `SMSC_DEF_R1, `SMSC_DEF_R2, `SMSC_DEF_R3,
        `SMSC_DEF_R4, `SMSC_DEF_R5, `SMSC_DEF_R6, `SMSC_DEF_R7};

    ////////////////////////////////////////////////////////////////////////
    // serial clock domain: only the shift register lives here

    logic [`SMSC_WORD_W-1:0] shift_q;

    // no reset: the link clock may stand still, the word is rewritten anyway
    always_ff @(posedge sclk) begin
        shift_q <= {shift_q[`SMSC_WORD_W-2:0], sdata}; // [R01] [R02]
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic le_s1_q, le_s2_q, le_prev_q;
    logic en_s1_q, en_s2_q;
    logic drv_s1_q, drv_s2_q;
    logic ref_s1_q, ref_s2_q;
    logic lock_s1_q, lock_s2_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            le_s1_q <= 1'b0;
            le_s2_q <= 1'b0;
            le_prev_q <= 1'b0;
        end else begin
            le_s1_q <= load_strobe;
            le_s2_q <= le_s1_q;
            le_prev_q <= le_s2_q;
        end
    end

    // pull-down on the driver pin: reset value and board resistor keep it 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
            drv_s1_q <= 1'b0; // [R11]
            drv_s2_q <= 1'b0; // [R11]
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
        end else begin
            en_s1_q <= synth_enable_pin;
            en_s2_q <= en_s1_q;
            drv_s1_q <= lo_driver_pin;
            drv_s2_q <= drv_s1_q;
            ref_s1_q <= ref_in;
            ref_s2_q <= ref_s1_q;
            lock_s1_q <= lock_detect;
            lock_s2_q <= lock_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // commit of a word into the internal registers

    logic hold_q;
    logic load_rise;
    logic [`SMSC_SEL_W-1:0] load_sel;
    logic [`SMSC_WORD_W-1:0] reg_q [`SMSC_NUM_REGS];
    logic [7:0] load_count_q;

    // the word crosses by the strobe: the controller stops sclk before
    // raising it, so shift_q is quiet by the time the synced edge arrives
    assign load_rise = le_s2_q & ~le_prev_q & ~hold_q; // [R04] [R15]
    assign load_sel = shift_q[`SMSC_SEL_W-1:0]; // [R03]

    genvar gi;
    generate
        for (gi = 0; gi < `SMSC_NUM_REGS; gi++) begin : g_regs
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    reg_q[gi] <= DEFS[gi];
                end else if (load_rise && load_sel == gi) begin
                    reg_q[gi] <= shift_q; // [R03] [R04]
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_count_q <= 8'h00;
        end else if (load_rise) begin
            load_count_q <= load_count_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lo mode, pump and monitor

    logic synth_bit, drv_bit, lo_out;
    assign synth_bit = reg_q[`SMSC_REG_LO][`SMSC_LO_SYNTH_BIT];
    assign drv_bit = reg_q[`SMSC_REG_LO][`SMSC_LO_DRV_BIT];
    // the register bit may enable outputs even with the driver pin low
    assign lo_out = en_s2_q & synth_bit & (drv_s2_q | drv_bit); // [R09] [R10]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lo_ctrl <= '0;
        end else begin
            lo_ctrl.synth_power <= en_s2_q & synth_bit; // [R06] [R07] [R08]
            lo_ctrl.lo_internal <= en_s2_q & synth_bit; // [R06] [R07] [R08]
            lo_ctrl.lo_port_pos_oe <= lo_out; // [R09] [R10]
            lo_ctrl.lo_port_neg_oe <= lo_out; // [R09] [R10]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pump_ctrl <= '0;
        end else begin
            pump_ctrl.current_sel <= reg_q[`SMSC_REG_PUMP]
                [`SMSC_PUMP_CUR_HI:`SMSC_PUMP_CUR_LO]; // [R12]
            pump_ctrl.ext_ref <=
                reg_q[`SMSC_REG_PUMP][`SMSC_PUMP_EXT_BIT]; // [R13]
        end
    end

    logic mon_sel;
    assign mon_sel = reg_q[`SMSC_REG_MON][`SMSC_MON_SEL_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            monitor_out <= 1'b0;
        end else begin
            monitor_out <= mon_sel ? lock_s2_q : ref_s2_q; // [R14]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    logic aw_got_q, w_got_q;
    logic [`SMSC_ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go;

    assign wr_go = aw_got_q & w_got_q & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            aw_addr_q <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_got_q <= 1'b0;
            end
            s_axi_awready <= ~aw_got_q & ~s_axi_awready & ~s_axi_bvalid
                & s_axi_awvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_wready <= 1'b0;
        end else begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_got_q <= 1'b0;
            end
            s_axi_wready <= ~w_got_q & ~s_axi_wready & ~s_axi_bvalid
                & s_axi_wvalid;
        end
    end

    // only the control word is writable; the eight mirrors ignore writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SMSC_RESP_OKAY;
        end else begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr_q == `SMSC_OFS_CTRL) begin
                    s_axi_bresp <= `SMSC_RESP_OKAY;
                    if (w_strb_q[0]) begin
                        hold_q <= w_data_q[`SMSC_CTRL_HOLD_BIT];
                    end
                end else if (aw_addr_q < `SMSC_OFS_STATUS + 8'h04
                             && aw_addr_q[1:0] == 2'b00) begin
                    s_axi_bresp <= `SMSC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `SMSC_RESP_DECERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic [31:0] rd_word;
    logic rd_hit;

    always_comb begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        if (s_axi_araddr[1:0] != 2'b00) begin
            rd_hit = 1'b0;
        end else if (s_axi_araddr < `SMSC_OFS_STATUS) begin
            rd_word = {8'h00, reg_q[s_axi_araddr[4:2]]};
        end else if (s_axi_araddr == `SMSC_OFS_STATUS) begin
            rd_word = {16'h0000, load_count_q, lo_ctrl, monitor_out,
                       pump_ctrl[2], en_s2_q, drv_s2_q};
        end else if (s_axi_araddr == `SMSC_OFS_CTRL) begin
            rd_word = {31'h00000000, hold_q};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `SMSC_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `SMSC_RESP_OKAY
                                      : `SMSC_RESP_DECERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    // the word has no reset: only bits with a known history are compared
    shift_in_a: assert property (@(posedge sclk) // [R01] [R02]
        ##4 shift_q[3:0] == {$past(sdata, 4), $past(sdata, 3),
                             $past(sdata, 2), $past(sdata)})
        else $error("shift register did not take serial data");

    load_sel_a: assert property ( // [R03]
        @(posedge aclk) disable iff (!aresetn)
        load_rise |=> reg_q[$past(load_sel)] == $past(shift_q))
        else $error("selected register did not take the word");

    load_only_a: assert property ( // [R04]
        @(posedge aclk) disable iff (!aresetn)
        !load_rise |=> reg_q[5] == $past(reg_q[5])
        && reg_q[4] == $past(reg_q[4]))
        else $error("register changed without a load strobe");

    strobe_edge_a: assert property ( // [R04]
        @(posedge aclk) disable iff (!aresetn)
        $rose(le_s2_q) && !hold_q
        |=> reg_q[$past(load_sel)] == $past(shift_q))
        else $error("strobe rise not committed");

    synth_mode_a: assert property ( // [R06] [R08]
        @(posedge aclk) disable iff (!aresetn)
        ##1 lo_ctrl.synth_power == ($past(en_s2_q) && $past(synth_bit))
        && lo_ctrl.lo_internal == lo_ctrl.synth_power)
        else $error("synthesizer mode wrong");

    pin_low_a: assert property ( // [R07]
        @(posedge aclk) disable iff (!aresetn)
        !en_s2_q |=> !lo_ctrl.synth_power
        && !lo_ctrl.lo_port_pos_oe)
        else $error("pin low did not select external lo");

    lo_input_a: assert property ( // [R09]
        @(posedge aclk) disable iff (!aresetn)
        (!en_s2_q || !synth_bit) |=> !lo_ctrl.lo_port_neg_oe)
        else $error("lo port driven while it must be input");

    lo_output_a: assert property ( // [R10]
        @(posedge aclk) disable iff (!aresetn)
        en_s2_q && synth_bit && (drv_s2_q || drv_bit)
        |=> lo_ctrl.lo_port_pos_oe && lo_ctrl.lo_port_neg_oe)
        else $error("lo port not driven");

    pump_sel_a: assert property ( // [R12] [R13]
        @(posedge aclk) disable iff (!aresetn)
        ##1 pump_ctrl.current_sel == $past(reg_q[4][11:10])
        && pump_ctrl.ext_ref == $past(reg_q[4][18]))
        else $error("pump settings do not follow register");

    monitor_a: assert property ( // [R14]
        @(posedge aclk) disable iff (!aresetn)
        ##1 monitor_out == ($past(mon_sel) ? $past(lock_s2_q)
                                           : $past(ref_s2_q)))
        else $error("monitor output wrong source");

    load_c: cover property (@(posedge aclk) disable iff (!aresetn)
        load_rise && load_sel == `SMSC_REG_LO);
    lo_out_c: cover property (@(posedge aclk) disable iff (!aresetn)
        lo_ctrl.lo_port_pos_oe);
    axi_rd_c: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready);
    hold_c: cover property (@(posedge aclk) disable iff (!aresetn)
        le_s2_q && !le_prev_q && hold_q);
    synth_c: cover property (@(posedge aclk) disable iff (!aresetn)
        lo_ctrl.synth_power && !lo_ctrl.lo_port_pos_oe);
endmodule

// file: verification/smsc_host_model.sv
// serial controller model that programs the mixer control port
`timescale 1ns/1ps
module smsc_host_model (
    // serial link
    output logic sclk,
    output logic sdata,
    output logic load_strobe
);
    // 25 ns half period keeps the link at 20 MHz at most
    localparam int half = 25;
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        load_strobe = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // msb first with the strobe low; the clock stands still after a word
    task automatic shift(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            sdata = w[i];
            #half sclk = 1'b1;
            #half sclk = 1'b0;
        end
        // data line means nothing now, so show the inverse of the last bit
        sdata = ~w[0];
    endtask
    // one pulse after the last edge; 4 aclk wide so the sync sees it
    task automatic commit();
        #30 load_strobe = 1'b1;
        #40 load_strobe = 1'b0;
        #40;
    endtask
endmodule

// file: verification/tb_smsc_top.sv
// self-checking bench for the mixer serial control block
`timescale 1ns/1ps
`include "smsc_params.svh"
module tb_smsc_top;
    import smsc_pkg::*;
    localparam logic [1:0] ok = `SMSC_RESP_OKAY;
    localparam logic [1:0] derr = `SMSC_RESP_DECERR;
    logic aclk, aresetn, sclk, sdata, load_strobe, monitor_out;
    logic synth_enable_pin, lo_driver_pin, ref_in, lock_detect;
    smsc_lo_type lo_ctrl;
    smsc_pump_type pump_ctrl;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int errors = 0, n_tests = 0, nload = 0;
    bit hold = 0;
    logic [23:0] m [8];
    logic [1:0] bq [$];
    logic [33:0] rq [$];
    logic [33:0] e;
    smsc_top DUT (.aclk, .aresetn, .sclk, .sdata, .load_strobe,
        .synth_enable_pin, .lo_driver_pin, .ref_in, .lock_detect, .lo_ctrl,
        .pump_ctrl, .monitor_out, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    smsc_host_model host (.sclk, .sdata, .load_strobe);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // responses are judged here, in order of issue
    always @(posedge aclk) begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
            check(s_axi_bresp, bq.pop_front());
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            e = rq.pop_front();
            // data of a refused read carries no meaning
            check({s_axi_rresp, e[33:32] == derr ? 32'h0 : s_axi_rdata}, e);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        bq.push_back(er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        rq.push_back({er, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask
    // mode bit 0 shifts, bit 1 commits; latency is fixed by the design
    task automatic send(input logic [23:0] w, input logic [1:0] mode);
        if (mode[0]) host.shift(w);
        if (mode[1] && !hold) begin
            m[w[2:0]] = w;
            nload++;
        end
        if (mode[1]) host.commit();
        repeat (8) @(posedge aclk);
    endtask
    function automatic logic [7:0] exp_out();
        logic on;
        on = synth_enable_pin & m[5][6];
        return {on, on, {2{on & (lo_driver_pin | m[5][3])}}, m[4][11:10],
            m[4][18], m[3][4] ? lock_detect : ref_in};
    endfunction
    function automatic logic [31:0] stat();
        logic [7:0] o;
        o = exp_out();
        return {16'h0, nload[7:0], o[7:4], o[0], m[4][11], synth_enable_pin,
            lo_driver_pin};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [23:0] w;
        logic [31:0] r;
        void'($urandom(92439));
        {aresetn, synth_enable_pin, lo_driver_pin, ref_in, lock_detect} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        m = '{`SMSC_DEF_R0, `SMSC_DEF_R1, `SMSC_DEF_R2, `SMSC_DEF_R3,
            `SMSC_DEF_R4, `SMSC_DEF_R5, `SMSC_DEF_R6, `SMSC_DEF_R7};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++) rd(8'(i * 4), {8'h0, m[i]}, ok);
        check({lo_ctrl, pump_ctrl, monitor_out}, exp_out());
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            send({r[20:0], 3'(i)}, 2'b11);
            rd(8'(i * 4), {8'h0, m[i]}, ok);
        end
        r = $urandom;
        w = {r[20:0], 3'd2};
        send(w, 2'b01);
        rd(8'h08, {8'h0, m[2]}, ok);
        send(w, 2'b10);
        rd(8'h08, {8'h0, w}, ok);
        wr(`SMSC_OFS_CTRL, 32'h1, ok);
        hold = 1'b1;
        send({r[31:11], 3'd2}, 2'b11);
        rd(8'h08, {8'h0, w}, ok);
        rd(`SMSC_OFS_CTRL, 32'h1, ok);
        rd(`SMSC_OFS_STATUS, stat(), ok);
        wr(`SMSC_OFS_CTRL, 32'h0, ok);
        hold = 1'b0;
        // hold lives in byte lane 0: a write without that lane is ignored
        s_axi_wstrb <= 4'he;
        wr(`SMSC_OFS_CTRL, 32'h1, ok);
        s_axi_wstrb <= 4'hf;
        rd(`SMSC_OFS_CTRL, 32'h0, ok);
        // mirror is read-only; odd and unmapped places are refused
        wr(8'h00, $urandom, ok);
        rd(8'h00, {8'h0, m[0]}, ok);
        rd(8'h02, 32'h0, derr);
        rd(8'h28, 32'h0, derr);
        wr(8'h30, 32'h0, derr);
        for (int k = 0; k < 16; k++) begin
            r = $urandom;
            @(posedge aclk);
            synth_enable_pin <= k[2];
            lo_driver_pin <= k[3];
            ref_in <= r[30];
            lock_detect <= r[31];
            send({r[23:7], k[0], 2'b0, k[1], 3'd5}, 2'b11);
            send({r[18:0], k[0], 1'b0, 3'd3}, 2'b11);
            w = {r[23:19], k[2], r[17:12], k[1:0], r[9:3], 3'd4};
            send(w, 2'b11);
            check({lo_ctrl, pump_ctrl, monitor_out}, exp_out());
            rd(`SMSC_OFS_STATUS, stat(), ok);
        end
        // reset in mid-run: registers, count and outputs go back to defaults
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        m = '{`SMSC_DEF_R0, `SMSC_DEF_R1, `SMSC_DEF_R2, `SMSC_DEF_R3,
            `SMSC_DEF_R4, `SMSC_DEF_R5, `SMSC_DEF_R6, `SMSC_DEF_R7};
        nload = 0;
        rd(8'h14, {8'h0, m[5]}, ok);
        rd(`SMSC_OFS_STATUS, stat(), ok);
        check({lo_ctrl, pump_ctrl, monitor_out}, exp_out());
        r = $urandom;
        send({r[20:0], 3'd5}, 2'b11);
        rd(8'h14, {8'h0, m[5]}, ok);
        @(posedge aclk);
        give_verdict();
    end
    // about 85 us of traffic expected; 900 us means a hang
    initial begin
        #900000;
        errors++;
        give_verdict();
    end
endmodule
